// ---- rtl/ssr_defs.svh ----
`ifndef SSR_DEFS_SVH
`define SSR_DEFS_SVH

// Clock rate and timing
`define SSR_CLK_MHZ 50
`define SSR_POR_TIME_NS 20000
`define SSR_POR_CYC ((`SSR_POR_TIME_NS * `SSR_CLK_MHZ + 999) / 1000)
`define SSR_PIN_MIN_NS 1000
`define SSR_PIN_CYC ((`SSR_PIN_MIN_NS * `SSR_CLK_MHZ + 999) / 1000)

// First fetch address after power-up
`define SSR_BOOT_ADDR 32'h0000_0000

// Register byte offsets
`define SSR_OFF_CTRL 5'h00
`define SSR_OFF_STAT 5'h04
`define SSR_OFF_WCTL 5'h08
`define SSR_OFF_WLOAD 5'h0C
`define SSR_OFF_WCNT 5'h10
`define SSR_OFF_PRST 5'h14

// Control register fields
`define SSR_CTRL_MON_DIS 0
`define SSR_CTRL_IO_SUP 1
`define SSR_CTRL_MSK_CORE 2
`define SSR_CTRL_MSK_IO 3

// Watchdog control fields
`define SSR_WCTL_WDG_EN 0
`define SSR_WCTL_TMR_RUN 1
`define SSR_WCTL_PRE_LO 8

// Status fields beyond the cause bits
`define SSR_STAT_CSAG 8
`define SSR_STAT_ISAG 9
`define SSR_STAT_NVSEL 10

// Cause bits
`define SSR_C_CORE 0
`define SSR_C_IO 1
`define SSR_C_WDG 2
`define SSR_C_PIN 3
`define SSR_C_JTAG 4
`define SSR_C_PWRUP 5
`define SSR_CAUSE_RST 6'h20

// Synchroniser lanes
`define SSR_SY_ISAG 0
`define SSR_SY_CSAG 1
`define SSR_SY_IOHI 2
`define SSR_SY_IOLO 3
`define SSR_SY_CORE 4
`define SSR_SY_PIN 5
`define SSR_SY_JTAG 6
`define SSR_SY_DBG 7
`define SSR_SY_NV 8

`endif

// ---- rtl/ssr_pkg.sv ----
package ssr_pkg;

  typedef enum logic [1:0] {SSR_WAIT, SSR_HOLD, SSR_RUN} ssr_st_t;

  typedef struct packed {
    logic core_drop;
    logic io_drop_lo;
    logic io_drop_hi;
    logic core_sag;
    logic io_sag;
  } ssr_sup_t;

  typedef struct packed {
    logic global_reset_b;
    logic system_reset_b;
    logic ccu_reset_b;
    logic tap_reset_b;
  } ssr_rst_t;

  typedef struct packed {
    ssr_st_t st;
    logic glb;
    logic [15:0] hold;
    logic [8:0] sy1;
    logic [8:0] sy2;
    logic jtag_prev;
    logic [7:0] pin_cnt;
    logic [3:0] ctrl;
    logic wdg_en;
    logic tmr_run;
    logic [7:0] pre_div;
    logic [7:0] pre_cnt;
    logic [15:0] reload;
    logic [15:0] cnt;
    logic [7:0] periph;
    logic [5:0] cause;
    logic irq;
    ssr_rst_t rst;
    logic board_drv_low;
    logic [31:0] boot_addr;
    logic waitreq;
    logic [31:0] rdata;
  } ssr_state_t;

endpackage

// ---- rtl/ssr_supervisor.sv ----
// Our own choices: the placing of the registers and the Avalon-MM register port.
`timescale 1ns/1ps
`default_nettype none
`include "ssr_defs.svh"

// Contract
// [RQ1] Global reset clears all; system reset spares clock control, status.
// [RQ2] Core or I/O supply drop-out and power-up cause a global reset.
// [RQ3] Watchdog, board reset pin and JTAG command cause a system reset.
// [RQ4] Status shows watchdog or supply cause; only power-up clears it.
// [RQ5] Firmware can reset each peripheral on its own at any time.
// [RQ6] Sag on either supply raises an early brown-out interrupt.
// [RQ7] Firmware mask bits suppress brown-out interrupts.
// [RQ8] Core supply drop always gives a global reset, not maskable; the code gives none while the monitor-off bit is set.
// [RQ9] I/O threshold picks one of two levels from a non-volatile setting.
// [RQ10] A control bit lets firmware suppress some supply-monitor resets.
// [RQ11] Firmware can switch the supply monitor off entirely.
// [RQ12] 16-bit down-counter with 8-bit prescaler, watchdog or free timer.
// [RQ13] Enabled watchdog reaching zero before reload gives a system reset.
// [RQ14] Watchdog is off after any reset until firmware enables it.
// [RQ15] Board reset pin held low for the minimum time gives system reset.
// [RQ16] Board reset output is low for the power-up reset duration.
// [RQ17] Reset held until both supplies are good, then for the hold time.
// [RQ18] After power-up the first fetch comes from flash address zero.
// [RQ19] In debug mode a JTAG reset command gives a system reset.
// [RQ20] System resets leave the JTAG TAP controllers alone.
// [RQ21] Requests are synchronised; resets release on one clock edge.
// [RQ22] Global wins over system; status records the highest cause.
module ssr_supervisor
  import ssr_pkg::*;
(
  input wire logic core_clk,
  input wire logic rst_b,
  input wire logic [4:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  input wire ssr_sup_t supply_monitor,
  input wire logic board_reset_request_low,
  input wire logic jtag_reset_cmd,
  input wire logic jtag_debug_mode,
  input wire logic nv_io_thresh_sel,
  output var ssr_rst_t rst_o,
  output logic board_reset_drive_low,
  output logic bo_irq,
  output logic [7:0] periph_reset,
  output logic [31:0] boot_fetch_addr
);

  localparam int POR_N = `SSR_POR_CYC;
  localparam int PIN_N = `SSR_PIN_CYC;

  ssr_state_t q;
  ssr_state_t d;

  logic mon_on;
  logic core_rq;
  logic io_drop;
  logic io_rq;
  logic pin_rq;
  logic jtag_rq;
  logic wdg_rq;
  logic tick;
  logic glb_rq;
  logic sys_rq;
  logic acc;
  logic [31:0] wword;
  logic [31:0] rword;

  // Byte-lane merge of a write into a register image
  function automatic logic [31:0] be_merge(
    input logic [31:0] old,
    input logic [31:0] wd,
    input logic [3:0] be
  );
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++)
    begin
      if (be[i])
      begin
        r[8*i +: 8] = wd[8*i +: 8];
      end
    end
    return r;
  endfunction

  // Register image as software sees it
  function automatic logic [31:0] reg_image(
    input ssr_state_t s,
    input logic [4:0] a
  );
    logic [31:0] r;
    r = 32'h0000_0000;
    case (a)
      `SSR_OFF_CTRL: r[3:0] = s.ctrl;
      `SSR_OFF_STAT:
      begin
        r[5:0] = s.cause;
        r[`SSR_STAT_CSAG] = s.sy2[`SSR_SY_CSAG];
        r[`SSR_STAT_ISAG] = s.sy2[`SSR_SY_ISAG];
        r[`SSR_STAT_NVSEL] = s.sy2[`SSR_SY_NV];
      end
      `SSR_OFF_WCTL:
      begin
        r[`SSR_WCTL_WDG_EN] = s.wdg_en;
        r[`SSR_WCTL_TMR_RUN] = s.tmr_run;
        r[`SSR_WCTL_PRE_LO +: 8] = s.pre_div;
      end
      `SSR_OFF_WLOAD: r[15:0] = s.reload;
      `SSR_OFF_WCNT: r[15:0] = s.cnt;
      `SSR_OFF_PRST: r[7:0] = s.periph;
      default: r = 32'h0000_0000;
    endcase
    return r;
  endfunction

  always_comb
  begin
    d = q;
    // Two-flop synchronisers; only sy2 is read by logic
    d.sy1 = {nv_io_thresh_sel, jtag_debug_mode, jtag_reset_cmd,
      board_reset_request_low, supply_monitor}; // RQ21
    d.sy2 = q.sy1; // RQ21
    d.jtag_prev = q.sy2[`SSR_SY_JTAG];

    mon_on = !q.ctrl[`SSR_CTRL_MON_DIS]; // RQ11
    // The suppress bit never touches the core drop-out path
    core_rq = q.sy2[`SSR_SY_CORE] && mon_on; // RQ8
    io_drop = q.sy2[`SSR_SY_NV] ? q.sy2[`SSR_SY_IOHI]
      : q.sy2[`SSR_SY_IOLO]; // RQ9
    io_rq = io_drop && mon_on && !q.ctrl[`SSR_CTRL_IO_SUP]; // RQ10

    // Low-time filter on the board reset pin
    if (q.sy2[`SSR_SY_PIN])
    begin
      d.pin_cnt = 8'h00;
    end
    else if (q.pin_cnt != 8'(PIN_N))
    begin
      d.pin_cnt = q.pin_cnt + 8'h01;
    end
    pin_rq = (q.pin_cnt == 8'(PIN_N)); // RQ15

    jtag_rq = q.sy2[`SSR_SY_JTAG] && !q.jtag_prev
      && q.sy2[`SSR_SY_DBG]; // RQ19

    // Prescaled down-counter
    tick = (q.pre_cnt == q.pre_div);
    if (q.wdg_en || q.tmr_run)
    begin
      d.pre_cnt = tick ? 8'h00 : q.pre_cnt + 8'h01; // RQ12
      if (tick)
      begin
        if (q.cnt != 16'h0000)
        begin
          d.cnt = q.cnt - 16'h0001; // RQ12
        end
        else if (!q.wdg_en)
        begin
          // Free-running timer wraps to the reload value
          d.cnt = q.reload; // RQ12
        end
      end
    end
    wdg_rq = q.wdg_en && (q.cnt == 16'h0000); // RQ13

    glb_rq = core_rq || io_rq; // RQ2
    sys_rq = wdg_rq || pin_rq || jtag_rq; // RQ3

    // Brown-out warning, level until the sag goes away or its mask bit or the monitor-off bit is set
    d.irq = mon_on && ((q.sy2[`SSR_SY_CSAG]
      && !q.ctrl[`SSR_CTRL_MSK_CORE])
      || (q.sy2[`SSR_SY_ISAG]
      && !q.ctrl[`SSR_CTRL_MSK_IO])); // RQ6 RQ7

    // Bus slave: waitrequest drops for one cycle per request
    acc = (avs_read || avs_write) && !q.waitreq;
    d.waitreq = !((avs_read || avs_write) && q.waitreq);
    rword = reg_image(q, avs_address);
    if ((avs_read || avs_write) && q.waitreq)
    begin
      d.rdata = rword;
    end
    wword = be_merge(rword, avs_writedata, avs_byteenable);
    if (avs_write && acc)
    begin
      case (avs_address)
        `SSR_OFF_CTRL: d.ctrl = wword[3:0];
        `SSR_OFF_WCTL:
        begin
          d.wdg_en = wword[`SSR_WCTL_WDG_EN];
          d.tmr_run = wword[`SSR_WCTL_TMR_RUN];
          d.pre_div = wword[`SSR_WCTL_PRE_LO +: 8];
        end
        `SSR_OFF_WLOAD:
        begin
          // A reload write also restarts the count
          d.reload = wword[15:0];
          d.cnt = wword[15:0]; // RQ13
          d.pre_cnt = 8'h00;
        end
        `SSR_OFF_PRST: d.periph = wword[7:0]; // RQ5
        default: d.periph = d.periph;
      endcase
    end

    // Reset sequencer
    case (q.st)
      SSR_WAIT:
      begin
        d.hold = 16'h0000;
        if (!glb_rq)
        begin
          d.st = SSR_HOLD; // RQ17
        end
      end
      SSR_HOLD:
      begin
        if (glb_rq)
        begin
          d.st = SSR_WAIT; // RQ22
          d.glb = 1'b1;
          d.hold = 16'h0000;
        end
        else if (sys_rq)
        begin
          d.hold = 16'h0000;
        end
        else if (q.hold == 16'(POR_N - 1))
        begin
          d.st = SSR_RUN; // RQ17
          d.glb = 1'b0;
        end
        else
        begin
          d.hold = q.hold + 16'h0001; // RQ17
        end
      end
      SSR_RUN:
      begin
        d.hold = 16'h0000;
        if (glb_rq)
        begin
          d.st = SSR_WAIT; // RQ2 RQ22
          d.glb = 1'b1;
        end
        else if (sys_rq)
        begin
          d.st = SSR_HOLD; // RQ3
          d.glb = 1'b0;
        end
      end
      default:
      begin
        d.st = SSR_WAIT;
        d.glb = 1'b1;
      end
    endcase

    // Cause record: set only, highest source only
    if (glb_rq && q.st != SSR_WAIT)
    begin
      d.cause[`SSR_C_CORE] = q.cause[`SSR_C_CORE] | core_rq; // RQ4 RQ22
      d.cause[`SSR_C_IO] = q.cause[`SSR_C_IO] | io_rq; // RQ4 RQ22
    end
    else if (!glb_rq && q.st != SSR_WAIT)
    begin
      if (wdg_rq)
      begin
        d.cause[`SSR_C_WDG] = 1'b1; // RQ4 RQ22
      end
      else if (pin_rq)
      begin
        d.cause[`SSR_C_PIN] = 1'b1; // RQ22
      end
      else if (jtag_rq)
      begin
        d.cause[`SSR_C_JTAG] = 1'b1; // RQ22
      end
    end

    // Every register except the cause record returns to default in reset
    if (d.st != SSR_RUN)
    begin
      d.ctrl = 4'h0; // RQ1
      d.wdg_en = 1'b0; // RQ14
      d.tmr_run = 1'b0;
      d.pre_div = 8'h00;
      d.pre_cnt = 8'h00;
      d.reload = 16'h0000;
      d.cnt = 16'h0000;
      d.periph = 8'h00;
    end

    // Outputs leave reset together on the same edge
    d.rst.system_reset_b = (d.st == SSR_RUN); // RQ21
    d.rst.global_reset_b = !(d.st != SSR_RUN && d.glb); // RQ1
    d.rst.ccu_reset_b = d.rst.global_reset_b; // RQ1
    // TAPs see only global resets; their own reset pin lives in the TAP
    d.rst.tap_reset_b = d.rst.global_reset_b; // RQ20
    d.board_drv_low = (d.st != SSR_RUN); // RQ16
    d.boot_addr = `SSR_BOOT_ADDR; // RQ18
  end

  always_ff @(posedge core_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      q <= '0;
      q.st <= SSR_WAIT;
      q.glb <= 1'b1;
      q.cause <= `SSR_CAUSE_RST; // RQ4
      q.board_drv_low <= 1'b1;
      q.waitreq <= 1'b1;
      q.boot_addr <= `SSR_BOOT_ADDR;
      q.sy2[`SSR_SY_PIN] <= 1'b1;
      q.sy1[`SSR_SY_PIN] <= 1'b1;
      q.jtag_prev <= 1'b1;
    end
    else
    begin
      q <= d;
    end
  end

  assign avs_readdata = q.rdata;
  assign avs_waitrequest = q.waitreq;
  assign rst_o = q.rst;
  assign board_reset_drive_low = q.board_drv_low;
  assign bo_irq = q.irq;
  assign periph_reset = q.periph;
  assign boot_fetch_addr = q.boot_addr;

  default clocking ck @(posedge core_clk);
  endclocking
  default disable iff (!rst_b);

  por_hold_len_a: // RQ17
  assert property ($rose(q.rst.system_reset_b)
    |-> $past(q.hold) == 16'(POR_N - 1))
  else $error("reset released before the hold time");

  core_drop_glb_a: // RQ8
  assert property (q.sy2[`SSR_SY_CORE] && !q.ctrl[`SSR_CTRL_MON_DIS]
    |=> !q.rst.global_reset_b && !q.rst.system_reset_b)
  else $error("core drop did not give a global reset");

  wdg_timeout_a: // RQ13
  assert property (q.wdg_en && q.cnt == 16'h0000 && q.st == SSR_RUN
    && !q.sy2[`SSR_SY_CORE] && !q.sy2[`SSR_SY_IOLO]
    && !q.sy2[`SSR_SY_IOHI]
    |=> !q.rst.system_reset_b && q.cause[`SSR_C_WDG])
  else $error("watchdog timeout missed");

  wdg_off_reset_a: // RQ14
  assert property (!q.rst.system_reset_b |-> !q.wdg_en && !q.tmr_run)
  else $error("watchdog active during reset");

  ccu_spared_a: // RQ1
  assert property (q.rst.global_reset_b
    |-> q.rst.ccu_reset_b && q.rst.tap_reset_b)
  else $error("system reset hit clock control or TAP");

  board_out_a: // RQ16
  assert property ($fell(q.rst.system_reset_b)
    |-> q.board_drv_low [*8])
  else $error("board reset output not held");

  cause_sticky_a: // RQ4
  assert property ((q.cause & $past(q.cause)) == $past(q.cause))
  else $error("cause bit cleared without power-up");

  jtag_cmd_a: // RQ19
  assert property (q.sy2[`SSR_SY_JTAG] && !q.jtag_prev
    && q.sy2[`SSR_SY_DBG] |=> !q.rst.system_reset_b)
  else $error("JTAG reset command ignored");

  glb_priority_a: // RQ22
  assert property ((q.sy2[`SSR_SY_CORE] && !q.ctrl[`SSR_CTRL_MON_DIS])
    && q.pin_cnt == 8'(PIN_N) && q.st == SSR_RUN
    |=> q.st == SSR_WAIT && q.cause[`SSR_C_CORE]
    && q.cause[`SSR_C_PIN] == $past(q.cause[`SSR_C_PIN]))
  else $error("system cause beat a global one");

  pin_reset_a: // RQ15
  assert property (q.pin_cnt == 8'(PIN_N) |=> !q.rst.system_reset_b)
  else $error("board reset pin ignored");

  bus_answer_a: // Bus answer timing, our own choice; no contract rule
  assert property ((avs_read || avs_write) && q.waitreq
    |=> !q.waitreq ##1 q.waitreq)
  else $error("waitrequest did not answer in one cycle");

endmodule

`default_nettype wire

// ---- verif/ssr_far_side.sv ----
`timescale 1ns/1ps
`default_nettype none
`include "ssr_defs.svh"
module ssr_far_side
  import ssr_pkg::*;
(
  input wire logic core_clk,
  input wire ssr_sup_t sup_req,
  input wire logic pin_go,
  input wire logic jtag_go,
  input wire logic dbg_req,
  input wire logic nv_req,
  output var ssr_sup_t supply_monitor,
  output logic board_reset_request_low,
  output logic jtag_reset_cmd,
  output logic jtag_debug_mode,
  output logic nv_io_thresh_sel
);
  int pin_n;
  int jt_n;
  initial
  begin
    supply_monitor = '0;
    board_reset_request_low = 1'b1;
    jtag_reset_cmd = 1'b0;
    jtag_debug_mode = 1'b0;
    nv_io_thresh_sel = 1'b0;
    pin_n = 0;
    jt_n = 0;
  end
  always @(posedge core_clk)
  begin
    supply_monitor <= sup_req;
    nv_io_thresh_sel <= nv_req;
    jtag_debug_mode <= dbg_req;
    // Pin is pulled up, so it returns high when released
    board_reset_request_low <= (pin_n == 0);
    pin_n <= pin_go ? `SSR_PIN_CYC + 10
      : (pin_n > 0 ? pin_n - 1 : 0);
    jt_n <= jtag_go ? 8 : (jt_n > 0 ? jt_n - 1 : 0);
    // Command only while debug mode is held
    jtag_reset_cmd <= jtag_debug_mode && jt_n inside {[2:5]};
  end
endmodule
`default_nettype wire

// ---- verif/system_supervisor_reset_watchdog_bench.sv ----
`timescale 1ns/1ps
`default_nettype none
`include "ssr_defs.svh"
module system_supervisor_reset_watchdog_bench
  import ssr_pkg::*;
;
  logic core_clk = 1'b0;
  logic rst_b = 1'b0;
  logic [4:0] avs_address = '0;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [31:0] avs_writedata = '0;
  logic [31:0] avs_readdata;
  logic avs_waitrequest;
  ssr_sup_t supply_monitor;
  ssr_sup_t sup_req = '0;
  logic board_reset_request_low;
  logic jtag_reset_cmd;
  logic jtag_debug_mode;
  logic nv_io_thresh_sel;
  logic pin_go = 1'b0;
  logic jtag_go = 1'b0;
  logic dbg_req = 1'b0;
  logic nv_req = 1'b0;
  ssr_rst_t rst_o;
  logic board_reset_drive_low;
  logic bo_irq;
  logic [7:0] periph_reset;
  logic [31:0] boot_fetch_addr;
  logic [31:0] rd;
  logic [31:0] v;
  logic [5:0] cause_m = `SSR_CAUSE_RST;
  int failures = 0;
  int samples_checked = 0;
  int wn;
  int p;
  int ld;
  always #10 core_clk = ~core_clk;
  ssr_supervisor ssr_supervisor_i (.core_clk(core_clk), .rst_b(rst_b),
    .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_byteenable(4'hf),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .supply_monitor(supply_monitor),
    .board_reset_request_low(board_reset_request_low),
    .jtag_reset_cmd(jtag_reset_cmd), .jtag_debug_mode(jtag_debug_mode),
    .nv_io_thresh_sel(nv_io_thresh_sel), .rst_o(rst_o),
    .board_reset_drive_low(board_reset_drive_low), .bo_irq(bo_irq),
    .periph_reset(periph_reset), .boot_fetch_addr(boot_fetch_addr));
  ssr_far_side ssr_far_side_i (.core_clk(core_clk), .sup_req(sup_req),
    .pin_go(pin_go), .jtag_go(jtag_go), .dbg_req(dbg_req), .nv_req(nv_req),
    .supply_monitor(supply_monitor),
    .board_reset_request_low(board_reset_request_low),
    .jtag_reset_cmd(jtag_reset_cmd), .jtag_debug_mode(jtag_debug_mode),
    .nv_io_thresh_sel(nv_io_thresh_sel));
  task automatic results;
    $display("checks %0d failures %0d", samples_checked, failures);
    if (failures == 0 && samples_checked > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] seen, exp);
    samples_checked++;
    if (seen !== exp)
    begin
      failures++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic hang(input string nm);
    failures++;
    $display("[FAIL] %s timed out", nm);
    results();
  endtask
  // Called right after a rising edge; holds the request until accepted
  task automatic bus(input logic wr, input logic [4:0] a, input int d);
    int n;
    avs_address <= a;
    avs_writedata <= d;
    avs_write <= wr;
    avs_read <= !wr;
    n = 0;
    do
    begin
      @(posedge core_clk);
      n++;
    end
    while (avs_waitrequest !== 1'b0 && n < 50);
    rd = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    if (n >= 50)
      hang("bus");
    @(posedge core_clk);
  endtask
  task automatic wait_rst(input int idx, input logic lv, input int lim);
    wn = 0;
    while (rst_o[idx] !== lv && wn < lim)
    begin
      @(posedge core_clk);
      wn++;
    end
    if (wn >= lim)
      hang("reset line");
  endtask
  task automatic stat_chk;
    bus(0, `SSR_OFF_STAT, 0);
    chk("status", rd, {21'h0, nv_req, sup_req.io_sag, sup_req.core_sag,
      2'h0, cause_m});
  endtask
  initial
  begin
    void'($urandom(32'h8d16_bccd));
    repeat (8) @(posedge core_clk);
    chk("rst_o in reset", 32'(rst_o), 0);
    chk("drive low in reset", 32'(board_reset_drive_low), 1);
    rst_b <= 1'b1;
    wait_rst(3, 1'b1, 2000);
    chk("por length",
      32'(wn >= `SSR_POR_CYC && wn <= `SSR_POR_CYC + 8), 1);
    chk("release", {rst_o, board_reset_drive_low}, 5'h1e);
    chk("boot", boot_fetch_addr, `SSR_BOOT_ADDR);
    stat_chk();
    bus(0, `SSR_OFF_WCTL, 0);
    chk("wdg off", rd, 0);
    bus(0, 5'h1c, 0);
    chk("unmapped", rd, 0);
    sup_req.core_sag <= 1'b1;
    repeat (6) @(posedge core_clk);
    chk("core sag irq", 32'(bo_irq), 1);
    stat_chk();
    bus(1, `SSR_OFF_CTRL, 4);
    repeat (3) @(posedge core_clk);
    chk("core sag masked", 32'(bo_irq), 0);
    sup_req <= '{io_sag: 1'b1, default: 1'b0};
    repeat (6) @(posedge core_clk);
    chk("io sag irq", 32'(bo_irq), 1);
    stat_chk();
    bus(1, `SSR_OFF_CTRL, 8);
    repeat (3) @(posedge core_clk);
    chk("io sag masked", 32'(bo_irq), 0);
    sup_req <= '0;
    v = $urandom;
    bus(1, `SSR_OFF_PRST, v);
    chk("periph", 32'(periph_reset), v[7:0]);
    bus(1, `SSR_OFF_WCTL, 2);
    // Free-running timer from 3 must wrap back to the reload value
    bus(1, `SSR_OFF_WLOAD, 3);
    repeat (4) @(posedge core_clk);
    bus(0, `SSR_OFF_WCNT, 0);
    chk("timer wrap", rd, 2);
    bus(1, `SSR_OFF_WLOAD, 300);
    bus(0, `SSR_OFF_WCNT, 0);
    chk("timer runs", 32'(rd[15:0] < 300 && rst_o[2] === 1'b1), 1);
    p = $urandom % 4;
    ld = 20 + $urandom % 40;
    bus(1, `SSR_OFF_WCTL, (p << 8) | 3);
    bus(1, `SSR_OFF_WLOAD, ld);
    wait_rst(2, 1'b0, 400);
    chk("wdg time", 32'(wn + 3 >= (ld - 1) * (p + 1)
      && wn <= (ld + 2) * (p + 1) + 4), 1);
    chk("wdg kind", {rst_o[3], rst_o[1], rst_o[0]}, 3'h7);
    cause_m |= 6'h04;
    wait_rst(2, 1'b1, 2000);
    chk("periph cleared", 32'(periph_reset), 0);
    bus(0, `SSR_OFF_WCTL, 0);
    chk("wdg off again", rd, 0);
    stat_chk();
    pin_go <= 1'b1;
    @(posedge core_clk);
    pin_go <= 1'b0;
    wait_rst(2, 1'b0, 200);
    chk("pin kind", {rst_o[3], rst_o[1], rst_o[0],
      board_reset_drive_low}, 4'hf);
    cause_m |= 6'h08;
    wait_rst(2, 1'b1, 2000);
    dbg_req <= 1'b1;
    jtag_go <= 1'b1;
    @(posedge core_clk);
    jtag_go <= 1'b0;
    wait_rst(2, 1'b0, 100);
    chk("jtag kind", {rst_o[3], rst_o[1], rst_o[0]}, 3'h7);
    cause_m |= 6'h10;
    wait_rst(2, 1'b1, 2000);
    dbg_req <= 1'b0;
    stat_chk();
    bus(1, `SSR_OFF_CTRL, 2);
    sup_req.io_drop_lo <= 1'b1;
    repeat (20) @(posedge core_clk);
    chk("io drop suppressed", 32'(rst_o[3]), 1);
    sup_req.core_drop <= 1'b1;
    wait_rst(3, 1'b0, 20);
    chk("core drop tap", 32'({rst_o[1], rst_o[0]}), 0);
    sup_req <= '0;
    cause_m |= 6'h01;
    wait_rst(3, 1'b1, 2000);
    stat_chk();
    nv_req <= 1'b1;
    sup_req.io_drop_hi <= 1'b1;
    wait_rst(3, 1'b0, 20);
    sup_req <= '0;
    cause_m |= 6'h02;
    wait_rst(3, 1'b1, 2000);
    stat_chk();
    bus(1, `SSR_OFF_CTRL, 1);
    sup_req.core_drop <= 1'b1;
    repeat (20) @(posedge core_clk);
    chk("monitor off", 32'(rst_o[3]), 1);
    sup_req <= '0;
    rst_b <= 1'b0;
    repeat (2) @(posedge core_clk);
    rst_b <= 1'b1;
    cause_m = `SSR_CAUSE_RST;
    wait_rst(3, 1'b1, 2000);
    stat_chk();
    results();
  end
endmodule
`default_nettype wire
